// >>> rtl/acc_pkg.sv
package acc_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [7:0] ACC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] ACC_OFS_POS_CH  = 8'h04;
  localparam logic [7:0] ACC_OFS_NEG_CH  = 8'h08;
  localparam logic [7:0] ACC_OFS_STATUS  = 8'h0c;
  localparam logic [7:0] ACC_OFS_RESULT  = 8'h10;
  localparam logic [7:0] ACC_OFS_IRQ_EN  = 8'h14;
  localparam logic [7:0] ACC_OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] ACC_OFS_RESET   = 8'h1c;

  // Control register field positions.
  localparam int ACC_BIT_CONV_EN  = 7;
  localparam int ACC_BIT_BUSY_EN  = 6;
  localparam int ACC_BIT_POWER    = 5;
  localparam int ACC_POS_MODE     = 3;
  localparam int ACC_POS_TRIG     = 0;

  // Result word layout.
  localparam int ACC_RES_LSB   = 16;
  localparam int ACC_RES_MSB   = 27;
  localparam int ACC_SIGN_LSB  = 28;
  localparam int ACC_DATA_W    = 12;

  // Values after reset.
  localparam logic [7:0]  ACC_CONTROL_RST = 8'h00;
  localparam logic [4:0]  ACC_CHAN_RST    = 5'h00;
  localparam logic [31:0] ACC_RESULT_RST  = 32'h0000_0000;

  // Temperature sensor channel code.
  localparam logic [4:0] ACC_CH_TEMP = 5'h10;

  // Timing: 1 MSPS at 40 MHz gives 40 source clocks per conversion.
  localparam int ACC_CLK_HZ      = 40_000_000;
  localparam int ACC_RATE_SPS    = 1_000_000;
  localparam int ACC_CONV_CYCLES = ACC_CLK_HZ / ACC_RATE_SPS;
  localparam logic [5:0] ACC_CONV_LAST = 6'(ACC_CONV_CYCLES - 1);

  typedef enum logic [1:0] {
    ACC_MODE_SINGLE = 2'b00,
    ACC_MODE_DIFF   = 2'b01,
    ACC_MODE_PSEUDO = 2'b10
  } acc_mode_e;

  typedef enum logic [2:0] {
    ACC_TRIG_PIN    = 3'b000,
    ACC_TRIG_TIMER1 = 3'b001,
    ACC_TRIG_TIMER0 = 3'b010,
    ACC_TRIG_SW_ONE = 3'b011,
    ACC_TRIG_SW_RUN = 3'b100,
    ACC_TRIG_PLOGIC = 3'b101
  } acc_trig_e;

  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b00,
    ACC_ST_CONV = 2'b01,
    ACC_ST_DONE = 2'b10
  } acc_state_e;

endpackage

// >>> rtl/acc_sync.sv
`timescale 1ns/100ps
// Three-stage input synchroniser with agreement filter and rise detector.
module acc_sync
  import acc_pkg::*;
(
  input  wire logic sys_clk,   // System clock.
  input  wire logic rst,       // Synchronous reset, active high.
  input  wire logic async_in,  // Raw input from outside the domain.
  output logic      level,     // Filtered level.
  output logic      rise       // One-cycle pulse on a filtered rise.
);

  typedef struct packed {
    logic [2:0] stage;
    logic       level;
    logic       rise;
  } acc_sync_s;

  acc_sync_s sync_reg;
  acc_sync_s sync_next;

  // The first stage feeds only the second; the filter looks at 2 and 3.
  always_comb begin
    sync_next       = sync_reg;
    sync_next.stage = {sync_reg.stage[1:0], async_in};
    sync_next.rise  = 1'b0;
    if (sync_reg.stage[1] == sync_reg.stage[2]) begin
      sync_next.level = sync_reg.stage[2];
      sync_next.rise  = sync_reg.stage[2] & ~sync_reg.level;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.level;
  assign rise  = sync_reg.rise;

endmodule

// >>> rtl/acc_ctrl.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
// Operation
// - Result sits in bits 16 to 27.
// - Top four bits copy the sign.
// - Single-ended, pseudo-differential: straight binary, 4096 codes.
// - Fully differential: two's complement, 4096 codes.
// - Three software-selectable input configurations.
// - Software single or continuous conversion.
// - Hardware triggers: pin, logic block, timers.
// - Temperature sensor is an extra channel.
// - Sequencing takes 40 clocks per conversion; continuous runs restart every 41 clocks, about 975,600 per second.
// - Status bit 0 sets at end, clears on a result read.
// - Enabled busy pin high during conversion.
// - Two-bit mode field selects input configuration.
// - Three-bit trigger field selects start source.
module acc_ctrl
  import acc_pkg::*;
(
  input  wire logic        sys_clk,                      // System clock.
  input  wire logic        rst,                          // Sync reset.
  input  wire logic [7:0]  reg_addr,                     // Register address.
  input  wire logic [31:0] reg_wdata,                    // Write data.
  input  wire logic        reg_wr,                       // Write strobe.
  input  wire logic        reg_rd,                       // Read strobe.
  output logic      [31:0] reg_rdata,                    // Read data.
  output logic             irq,                          // Interrupt level.
  input  wire logic        external_convert_trigger_pin, // Start pin.
  input  wire logic        timer0_overflow,              // Timer0 pulse.
  input  wire logic        timer1_overflow,              // Timer1 pulse.
  input  wire logic        programmable_logic_block,     // Logic output.
  output logic             conversion_active_pin,        // Busy pin.
  output logic             sar_start,                    // Sample pulse.
  output logic      [4:0]  sar_pos_channel,              // Positive mux.
  output logic      [4:0]  sar_neg_channel,              // Negative mux.
  output logic      [1:0]  sar_mode,                     // Input config.
  output logic             sar_power,                    // Power up.
  input  wire logic [11:0] sar_code,                     // Raw converter code.
  output logic             temp_channel_active           // Sensor selected.
);

  typedef struct packed {
    logic [7:0]  control;
    logic [4:0]  pos_ch;
    logic [4:0]  neg_ch;
    logic        status;
    logic        irq_en;
    logic [31:0] result;
    logic [31:0] rdata;
    acc_state_e  state;
    logic [5:0]  count;
    logic [1:0]  conv_mode;
    logic        sw_go;
    logic        busy;
    logic        start;
    logic        irq;
  } acc_ctrl_s;

  acc_ctrl_s ctrl_reg;
  acc_ctrl_s ctrl_next;

  logic pin_level;
  logic pin_rise;
  logic pl_level;
  logic pl_rise;

  // External sources pass the filtering synchroniser before use.
  acc_sync u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (external_convert_trigger_pin),
    .level    (pin_level),
    .rise     (pin_rise)
  );

  acc_sync u_pl_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (programmable_logic_block),
    .level    (pl_level),
    .rise     (pl_rise)
  );

  // Builds the result word from a raw code and the mode used.
  function automatic logic [31:0] acc_format(input logic [11:0] code,
                                             input logic [1:0]  mode);
    logic [31:0] word;
    logic        sign;
    word = 32'h0000_0000;
    sign = 1'b0;
    if (mode == ACC_MODE_DIFF) begin
      sign = code[ACC_DATA_W-1];
    end
    word[ACC_RES_MSB:ACC_RES_LSB]  = code;
    word[31:ACC_SIGN_LSB]          = {4{sign}};
    word[ACC_RES_LSB-1:0]          = 16'h0000;
    return word;
  endfunction

  // Picks the hardware trigger event for the selected source.
  function automatic logic acc_hw_event(input logic [2:0] trig,
                                        input logic       pin_e,
                                        input logic       t1_e,
                                        input logic       t0_e,
                                        input logic       pl_e);
    logic hit;
    hit = 1'b0;
    case (trig)
      ACC_TRIG_PIN:    hit = pin_e;
      ACC_TRIG_TIMER1: hit = t1_e;
      ACC_TRIG_TIMER0: hit = t0_e;
      ACC_TRIG_PLOGIC: hit = pl_e;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [2:0] trig;
  logic       hw_go;
  logic       conv_ok;
  logic       rd_result;

  assign trig      = ctrl_reg.control[ACC_POS_TRIG +: 3];
  assign conv_ok   = ctrl_reg.control[ACC_BIT_CONV_EN] &
                     ctrl_reg.control[ACC_BIT_POWER];
  assign rd_result = reg_rd && (reg_addr == ACC_OFS_RESULT);
  // Timer overflows come from logic on this clock, so no synchroniser.
  assign hw_go     = acc_hw_event(trig, pin_rise, timer1_overflow,
                                  timer0_overflow, pl_rise);

  // Register writes, conversion sequencing, status and read path.
  always_comb begin
    ctrl_next       = ctrl_reg;
    ctrl_next.start = 1'b0;
    ctrl_next.rdata = 32'h0000_0000;

    // Software writes; reserved mode 11 is refused and the old mode kept.
    if (reg_wr) begin
      if (reg_addr == ACC_OFS_CONTROL) begin
        ctrl_next.control = reg_wdata[7:0];
        if (reg_wdata[ACC_POS_MODE +: 2] == 2'b11) begin
          ctrl_next.control[ACC_POS_MODE +: 2] =
            ctrl_reg.control[ACC_POS_MODE +: 2];
        end
        // A single or continuous software start arms on this write.
        ctrl_next.sw_go = (reg_wdata[ACC_POS_TRIG +: 3] == ACC_TRIG_SW_ONE)
                        | (reg_wdata[ACC_POS_TRIG +: 3] == ACC_TRIG_SW_RUN);
      end else if (reg_addr == ACC_OFS_POS_CH) begin
        ctrl_next.pos_ch = reg_wdata[4:0];
      end else if (reg_addr == ACC_OFS_NEG_CH) begin
        ctrl_next.neg_ch = reg_wdata[4:0];
      end else if (reg_addr == ACC_OFS_IRQ_EN) begin
        ctrl_next.irq_en = reg_wdata[0];
      end else if (reg_addr == ACC_OFS_IRQ_CLR) begin
        if (reg_wdata[0]) begin
          ctrl_next.status = 1'b0;
        end
      end else if (reg_addr == ACC_OFS_RESET) begin
        ctrl_next.control = ACC_CONTROL_RST;
        ctrl_next.pos_ch  = ACC_CHAN_RST;
        ctrl_next.neg_ch  = ACC_CHAN_RST;
        ctrl_next.status  = 1'b0;
        ctrl_next.irq_en  = 1'b0;
        ctrl_next.result  = ACC_RESULT_RST;
        ctrl_next.sw_go   = 1'b0;
      end
    end

    // Reading the result clears the ready flag.
    if (rd_result) begin
      ctrl_next.status = 1'b0;
    end

    // Conversion sequencer: ACC_CONV_CYCLES clocks per sample, one idle clock between samples.
    case (ctrl_reg.state)
      ACC_ST_IDLE: begin
        if (conv_ok && (ctrl_reg.sw_go || hw_go)) begin
          ctrl_next.state     = ACC_ST_CONV;
          ctrl_next.count     = 6'h00;
          ctrl_next.start     = 1'b1;
          ctrl_next.busy      = 1'b1;
          ctrl_next.conv_mode = ctrl_reg.control[ACC_POS_MODE +: 2];
          if (trig == ACC_TRIG_SW_ONE) begin
            ctrl_next.sw_go = 1'b0;
          end
        end
      end
      ACC_ST_CONV: begin
        ctrl_next.count = ctrl_reg.count + 6'h01;
        if (ctrl_reg.count == ACC_CONV_LAST - 6'h01) begin
          ctrl_next.state = ACC_ST_DONE;
        end
      end
      ACC_ST_DONE: begin
        // Mode is captured at start so a mid-conversion write cannot
        // reinterpret the code already in flight.
        ctrl_next.result = acc_format(sar_code, ctrl_reg.conv_mode);
        ctrl_next.status = 1'b1;
        ctrl_next.busy   = 1'b0;
        ctrl_next.state  = ACC_ST_IDLE;
        if (trig != ACC_TRIG_SW_RUN) begin
          ctrl_next.sw_go = 1'b0;
        end
      end
      default: begin
        ctrl_next.state = ACC_ST_IDLE;
        ctrl_next.busy  = 1'b0;
      end
    endcase

    // Continuous mode stops once conversion enable is cleared.
    if (!ctrl_next.control[ACC_BIT_CONV_EN]) begin
      ctrl_next.sw_go = 1'b0;
    end

    // Read data, valid only in the cycle after the strobe.
    if (reg_rd) begin
      if (reg_addr == ACC_OFS_CONTROL) begin
        ctrl_next.rdata = {24'h000000, ctrl_reg.control};
      end else if (reg_addr == ACC_OFS_POS_CH) begin
        ctrl_next.rdata = {27'h0000000, ctrl_reg.pos_ch};
      end else if (reg_addr == ACC_OFS_NEG_CH) begin
        ctrl_next.rdata = {27'h0000000, ctrl_reg.neg_ch};
      end else if (reg_addr == ACC_OFS_STATUS) begin
        ctrl_next.rdata = {31'h00000000, ctrl_reg.status};
      end else if (reg_addr == ACC_OFS_RESULT) begin
        ctrl_next.rdata = ctrl_reg.result;
      end else if (reg_addr == ACC_OFS_IRQ_EN) begin
        ctrl_next.rdata = {31'h00000000, ctrl_reg.irq_en};
      end else begin
        ctrl_next.rdata = 32'h0000_0000;
      end
    end

    // A completion in the same cycle as a clear still wins.
    if (ctrl_reg.state == ACC_ST_DONE) begin
      ctrl_next.status = 1'b1;
    end

    ctrl_next.irq = ctrl_next.status & ctrl_next.irq_en;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg           <= '0;
      ctrl_reg.control   <= ACC_CONTROL_RST;
      ctrl_reg.result    <= ACC_RESULT_RST;
      ctrl_reg.state     <= ACC_ST_IDLE;
      ctrl_reg.conv_mode <= ACC_MODE_SINGLE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Outputs from flip-flops, with the busy pin gated and the sensor flag decoded.
  assign reg_rdata             = ctrl_reg.rdata;
  assign irq                   = ctrl_reg.irq;
  assign conversion_active_pin = ctrl_reg.busy &
                                 ctrl_reg.control[ACC_BIT_BUSY_EN];
  assign sar_start             = ctrl_reg.start;
  assign sar_pos_channel       = ctrl_reg.pos_ch;
  assign sar_neg_channel       = ctrl_reg.neg_ch;
  assign sar_mode              = ctrl_reg.control[ACC_POS_MODE +: 2];
  assign sar_power             = ctrl_reg.control[ACC_BIT_POWER];
  assign temp_channel_active   = (ctrl_reg.pos_ch == ACC_CH_TEMP);

endmodule

// >>> tb/acc_ctrl_props.sv
`timescale 1ns/100ps
// Port-level checks of the converter control block.
module acc_ctrl_props
  import acc_pkg::*;
(
  input wire logic        sys_clk,               // Clock.
  input wire logic        rst,                   // Sync reset.
  input wire logic [7:0]  reg_addr,              // Address.
  input wire logic [31:0] reg_wdata,             // Write data.
  input wire logic        reg_wr,                // Write strobe.
  input wire logic        reg_rd,                // Read strobe.
  input wire logic [31:0] reg_rdata,             // Read data.
  input wire logic        irq,                   // Interrupt.
  input wire logic        conversion_active_pin, // Busy pin.
  input wire logic        sar_start,             // Start pulse.
  input wire logic [1:0]  sar_mode,              // Input config.
  input wire logic        temp_channel_active    // Sensor chosen.
);
  logic busy_en_reg;
  logic run_reg;
  // The busy pin is gated by a control bit, so shadow that bit here.
  always_ff @(posedge sys_clk) begin
    if (rst || (reg_wr && reg_addr == ACC_OFS_RESET)) begin
      busy_en_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (reg_wr && reg_addr == ACC_OFS_CONTROL) begin
      busy_en_reg <= reg_wdata[6];
      run_reg <= reg_wdata[7] && reg_wdata[5] && reg_wdata[2:0] == 3'h4;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_result_low:
    assert property (reg_rd && reg_addr == ACC_OFS_RESULT
      |=> reg_rdata[15:0] == 16'h0) else $error("low half not zero");
  chk_sign_copy:
    assert property (reg_rd && reg_addr == ACC_OFS_RESULT &&
      sar_mode == ACC_MODE_DIFF |=> reg_rdata[31:28] == {4{reg_rdata[27]}})
    else $error("sign bits wrong");
  chk_unsigned_fmt:
    assert property (reg_rd && reg_addr == ACC_OFS_RESULT &&
      sar_mode != ACC_MODE_DIFF |=> reg_rdata[31:28] == 4'h0)
    else $error("unsigned result has sign bits");
  // Busy rises with the start pulse and stands for forty clock cycles.
  chk_busy_span:
    assert property (sar_start && busy_en_reg |-> conversion_active_pin
      ##39 conversion_active_pin ##1 !conversion_active_pin)
    else $error("busy pin span wrong");
  chk_start_gap:
    assert property (sar_start |=> !sar_start [*8])
    else $error("start during conversion");
  chk_cont_rate:
    assert property (sar_start && run_reg |-> ##[41:43] (sar_start || !run_reg))
    else $error("continuous start missing");
  chk_irq_clear:
    assert property (reg_wr && reg_addr == ACC_OFS_IRQ_CLR && reg_wdata[0] &&
      !conversion_active_pin |-> ##2 !irq) else $error("irq not cleared");
  chk_temp_flag:
    assert property (reg_wr && reg_addr == ACC_OFS_POS_CH |=>
      temp_channel_active == ($past(reg_wdata[4:0]) == ACC_CH_TEMP))
    else $error("sensor flag wrong");
  cover property (sar_start && run_reg);
  cover property (reg_rd && reg_addr == ACC_OFS_RESULT && sar_mode == 2'h1);
  cover property ($rose(irq));
endmodule

// >>> tb/acc_src_model.sv
`timescale 1ns/100ps
// Converter code source and trigger lines facing the control block.
module acc_src_model
  import acc_pkg::*;
(
  input  wire logic        sys_clk,   // Clock.
  input  wire logic [3:0]  fire,      // Pin, timer0, timer1, logic.
  input  wire logic [11:0] code_in,   // Code for the next conversion.
  input  wire logic        sar_start, // Sample pulse.
  output logic      [11:0] sar_code,  // Code to the block.
  output logic      [3:0]  trig       // Trigger lines.
);
  logic [11:0] code_q = 12'h000;
  logic [5:0]  cnt = 6'h00;
  // The code is held only while converting; outside it shows the inverse
  // so that a sample taken at the wrong moment is caught.
  always @(posedge sys_clk) begin
    trig <= fire;
    if (sar_start) begin
      code_q <= code_in;
      cnt <= 6'h29;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
    end
  end
  assign sar_code = (cnt != 6'h00) ? code_q : ~code_q;
endmodule

// >>> tb/test_acc_ctrl.sv
`timescale 1ns/100ps
module test_acc_ctrl;
  import acc_pkg::*;
  logic        sys_clk, rst, reg_wr, reg_rd, irq, busy, sar_start;
  logic        sar_power, temp;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  pch, nch, ch;
  logic [1:0]  sar_mode, m;
  logic [11:0] sar_code, code_in;
  logic [3:0]  fire, trig;
  int          err_count, n_compared, nst, n0, seed = 84;
  logic [11:0] cor [5] = '{12'h000, 12'h800, 12'hfff, 12'h7ff, 12'hfff};
  logic [2:0]  tc [4] = '{3'h0, 3'h2, 3'h1, 3'h5};

  acc_ctrl DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .external_convert_trigger_pin(trig[0]),
    .timer0_overflow(trig[1]), .timer1_overflow(trig[2]),
    .programmable_logic_block(trig[3]), .conversion_active_pin(busy),
    .sar_start, .sar_pos_channel(pch), .sar_neg_channel(nch), .sar_mode,
    .sar_power, .sar_code, .temp_channel_active(temp));
  acc_src_model u_src (.sys_clk, .fire, .code_in, .sar_start, .sar_code,
    .trig);

  // Clock of 25 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Count conversion starts for the trigger scenarios.
  always @(posedge sys_clk) if (sar_start === 1'b1) nst++;

  // Expected result word from a raw code and the input mode.
  function automatic logic [31:0] fmt(logic [11:0] c, logic [1:0] md);
    return {(md == ACC_MODE_DIFF && c[11]) ? 4'hf : 4'h0, c, 16'h0};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // One software conversion; the busy pin follows its enable bit.
  task automatic conv(input logic [7:0] ctl);
    wr(ACC_OFS_CONTROL, {24'h0, ctl});
    repeat (2) @(posedge sys_clk);
    #1 chk(busy, ctl[6]);
    chk(sar_mode, ctl[4:3]);
    chk(sar_power, ctl[5]);
    repeat (45) @(posedge sys_clk);
    #1 chk(busy, 1'b0);
  endtask

  task automatic pulse(input logic [3:0] f);
    @(posedge sys_clk);
    fire <= f;
    repeat (6) @(posedge sys_clk);
    fire <= 4'h0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic conclude();
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, fire, code_in} = '0;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values; an unmapped address reads zero.
    rdc(ACC_OFS_CONTROL, 32'h0);
    rdc(ACC_OFS_RESULT, 32'h0);
    rdc(ACC_OFS_STATUS, 32'h0);
    rdc(8'h20, 32'h0);
    // The negative channel select reaches its pins and reads back.
    wr(ACC_OFS_NEG_CH, 32'h13);
    #1 chk(nch, 5'h13);
    rdc(ACC_OFS_NEG_CH, 32'h13);
    wr(ACC_OFS_IRQ_EN, 32'h1);
    // Every input mode, corner codes first and random ones after.
    for (int i = 0; i < 12; i++) begin
      m = 2'(i % 3);
      code_in <= (i < 5) ? cor[i] : 12'($random(seed));
      ch = (i == 5) ? ACC_CH_TEMP : 5'($random(seed));
      wr(ACC_OFS_POS_CH, {27'h0, ch});
      #1 chk(temp, ch == ACC_CH_TEMP);
      chk(pch, ch);
      conv({3'b111, m, 3'h3});
      chk(irq, 1'b1);
      rdc(ACC_OFS_STATUS, 32'h1);
      if (i[0]) wr(ACC_OFS_IRQ_CLR, 32'h1);
      rdc(ACC_OFS_RESULT, fmt(code_in, m));
      rdc(ACC_OFS_STATUS, 32'h0);
      chk(irq, 1'b0);
    end
    // A masked event keeps the line low until it is enabled.
    wr(ACC_OFS_IRQ_EN, 32'h0);
    conv(8'ha3);
    chk(irq, 1'b0);
    wr(ACC_OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    wr(ACC_OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    // Hardware sources: an unselected one is ignored.
    for (int t = 0; t < 4; t++) begin
      wr(ACC_OFS_CONTROL, {24'h0, 5'h1c, tc[t]});
      n0 = nst;
      pulse(4'h1 << ((t + 1) % 4));
      chk(nst, n0);
      pulse(4'h1 << t);
      chk(nst, n0 + 1);
      repeat (45) @(posedge sys_clk);
    end
    wr(ACC_OFS_CONTROL, 32'he6);
    n0 = nst;
    pulse(4'hf);
    chk(nst, n0);
    // Continuous conversions restart after one idle clock.
    code_in <= 12'($random(seed));
    n0 = nst;
    wr(ACC_OFS_CONTROL, 32'ha4);
    repeat (100) @(posedge sys_clk);
    chk(nst - n0, 1 + 100 / (ACC_CONV_CYCLES + 2));
    wr(ACC_OFS_CONTROL, 32'h0);
    repeat (50) @(posedge sys_clk);
    rdc(ACC_OFS_RESULT, {4'h0, code_in, 16'h0});
    // Reserved mode keeps the old one; soft reset clears control.
    wr(ACC_OFS_CONTROL, 32'h28);
    wr(ACC_OFS_CONTROL, 32'h38);
    rdc(ACC_OFS_CONTROL, 32'h28);
    wr(ACC_OFS_RESET, 32'h0);
    rdc(ACC_OFS_CONTROL, 32'h0);
    rdc(ACC_OFS_NEG_CH, 32'h0);
    conclude();
  end

  // Watchdog well beyond the roughly 1300 cycles the run needs.
  initial begin
    repeat (6000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
endmodule

bind acc_ctrl acc_ctrl_props u_props (.sys_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .conversion_active_pin,
  .sar_start, .sar_mode, .temp_channel_active);
